// ===== wgs_host.sv
// host model issuing single strobed commands to the sequencer
`timescale 1ns/10ps
module wgs_host (
	input  wire logic        sys_clk,
	output logic             cmd_valid,
	output wgs_pkg::wgs_op_t cmd_op,
	output logic [0:0]       cmd_gen,
	output logic [15:0]      cmd_arg
);
	// idle command lines at time zero
	initial begin
		cmd_valid = 1'h0;
		cmd_op = wgs_pkg::OP_MOTION;
		cmd_gen = 1'h0;
		cmd_arg = 16'h0;
	end

	// hold across one sampling edge, then scramble the released argument
	// so a stale word is never taken for a fresh one
	task automatic send(input wgs_pkg::wgs_op_t op, input logic g,
		input logic [15:0] a);
		@(negedge sys_clk);
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_gen <= g;
		cmd_arg <= a;
		@(negedge sys_clk);
		cmd_valid <= 1'h0;
		cmd_arg <= ~a;
	endtask : send
endmodule : wgs_host

// ===== wgs_pkg.sv
// constants and command codes of the wave generator sequencer
package wgs_pkg;
	localparam int CLK_MHZ         = 100;
	// servo cycle period limits and step in microseconds
	localparam int SERVO_MIN_US    = 100;
	localparam int SERVO_MAX_US    = 200;
	localparam int SERVO_STEP_US   = 25;
	localparam int SERVO_MIN_CYC   = SERVO_MIN_US * CLK_MHZ;
	localparam int SERVO_STEP_CYC  = SERVO_STEP_US * CLK_MHZ;
	// period code n selects SERVO_MIN_US + n * SERVO_STEP_US
	localparam logic [2:0] PERIOD_CODE_MAX  = 3'h4;
	localparam logic [2:0] PERIOD_CODE_DFLT = 3'h4;
	// start mode word fields
	localparam int MODE_W          = 16;
	localparam int MODE_IMM_BIT    = 0;
	localparam int MODE_TRIG_BIT   = 1;
	localparam int OPT_ENDPT_BIT   = 8;
	localparam logic [MODE_W-1:0] MODE_STOP = 16'h0000;
	// error codes
	localparam logic [7:0] ERR_NONE         = 8'h00;
	localparam logic [7:0] ERR_WAVE_STOPPED = 8'h0a;
	// volatile defaults
	localparam logic [15:0] RATE_DFLT     = 16'h0001;
	localparam logic [1:0]  TRIG_SEL_DFLT = 2'h0;
	localparam int TRIG_INPUTS    = 4;

	typedef enum logic [3:0] {
		OP_WAVE_OUTPUT_CONTROL,
		OP_GENERAL_STOP,
		OP_FAST_STOP,
		OP_RECORDING_RESTART,
		OP_CYCLE_LIMIT,
		OP_POINT_HOLD_RATE,
		OP_OUTPUT_OFFSET,
		OP_TRIGGER_CONFIG,
		OP_TABLE_LENGTH,
		OP_MOTION,
		OP_SERVO_MODE,
		OP_CONTROL_MODE
	} wgs_op_t;
endpackage : wgs_pkg

// ===== wgs_top.sv
// wave generator sequencer: servo tick, generators, command interlocks
// Summary of operation
// - generator outputs step only inside the servo cycle processing phase
// - start mode bit 0 starts at once, bit 1 waits on trigger level
// - option bit 8 starts each later cycle at previous cycle endpoint
// - wave control with mode 0 stops the named generator only
// - general stop or fast stop of running output sets error code 10
// - general stop or fast stop clears stored start modes to zero
// - nonzero cycle limit stops the generator when completed cycles reach it
// - immediate start pulses the data recording trigger
// - recording restart while output runs pulses the recording trigger
// - servo mode or control mode change refused while generator runs
// - motion commands for a running axis are refused
// - analog controlled axis keeps running but its values are not fed
// - analog controlled axis accepts stop but refuses start
// - trigger started output pauses on low trigger, pause is no stop
// - trigger selection is volatile and returns to default at reset
// - running mask output shows which generators run
// - stored start mode word of each generator is readable
// - servo period 100 to 200 us in 25 us steps, default 200
// - period code is taken only once after reset release
// - load indicator output, high share above 70 percent means overload
// - load indicator rises at servo cycle start, falls when processing ends
// - each point held for table rate servo cycles, default 1
// - emitted value is offset plus current point, plus the endpoint base when option bit 8 is set
`timescale 1ns/10ps
module wgs_top #(
	parameter int N_GEN     = 2,
	parameter int TBL_DEPTH = 16,
	parameter int PT_W      = 16,
	parameter int SERVO_MIN_CYC  = wgs_pkg::SERVO_MIN_CYC,
	parameter int SERVO_STEP_CYC = wgs_pkg::SERVO_STEP_CYC,
	// index widths are needed by the port list itself
	localparam int GW = (N_GEN > 1) ? $clog2(N_GEN) : 1,
	localparam int AW = $clog2(TBL_DEPTH)
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [2:0]                period_code_nv,
	input  wire logic                      cmd_valid,
	input  wire wgs_pkg::wgs_op_t          cmd_op,
	input  wire logic [GW-1:0]             cmd_gen,
	input  wire logic [15:0]               cmd_arg,
	output logic                           cmd_ack,
	output logic                           cmd_refused,
	input  wire logic                      tbl_we,
	input  wire logic [GW-1:0]             tbl_gen,
	input  wire logic [AW-1:0]             tbl_addr,
	input  wire logic [PT_W-1:0]           tbl_data,
	input  wire logic [wgs_pkg::TRIG_INPUTS-1:0] trig_in,
	input  wire logic [N_GEN-1:0]          analog_ctl,
	input  wire logic                      err_read,
	output logic [7:0]                     err_code,
	output logic [N_GEN-1:0]               running,
	output logic [N_GEN*wgs_pkg::MODE_W-1:0] start_mode,
	output logic [N_GEN*PT_W-1:0]          gen_value,
	output logic [N_GEN-1:0]               gen_value_valid,
	output logic                           rec_trigger,
	output logic                           load_ind
);
	localparam int CW  = $clog2(SERVO_MIN_CYC + 4 * SERVO_STEP_CYC + 1);
	localparam int PHW = GW;
	localparam int MW  = wgs_pkg::MODE_W;

	generate
		if (N_GEN < 1 || N_GEN > 4 || TBL_DEPTH < 2 ||
			TBL_DEPTH > 65536 || PT_W < 2 || SERVO_MIN_CYC < 2 ||
			SERVO_STEP_CYC < 0) begin : g_bad
			$error("wgs_top: unsupported parameter values");
		end
	endgenerate

	typedef struct packed {
		logic                             booted;
		logic [CW-1:0]                    period;
		logic [CW-1:0]                    per_cnt;
		logic                             busy;
		logic [PHW-1:0]                   phase;
		logic [7:0]                       err;
		logic                             rec_pulse;
		logic [N_GEN-1:0]                 run;
		logic [N_GEN-1:0]                 stop_pend;
		logic [N_GEN-1:0]                 trig_mode;
		logic [N_GEN-1:0]                 endpt;
		logic [N_GEN-1:0]                 val_pulse;
		logic [N_GEN-1:0][MW-1:0]         smode;
		logic [N_GEN-1:0][AW-1:0]         idx;
		logic [N_GEN-1:0][AW-1:0]         last;
		logic [N_GEN-1:0][15:0]           hold;
		logic [N_GEN-1:0][15:0]           rate;
		logic [N_GEN-1:0][15:0]           limit;
		logic [N_GEN-1:0][15:0]           done;
		logic [N_GEN-1:0][1:0]            trig_sel;
		logic [N_GEN-1:0][PT_W-1:0]       offset;
		logic [N_GEN-1:0][PT_W-1:0]       base;
		logic [N_GEN-1:0][PT_W-1:0]       value;
		logic [N_GEN-1:0][TBL_DEPTH-1:0][PT_W-1:0] tbl;
	} wgs_state_t;

	wgs_state_t q;
	wgs_state_t d;

	// next state: boot latch, servo divider, generator steps, commands
	always_comb begin
		logic          tick;
		logic          gen_ok;
		logic [CW-1:0] per_new;
		tick    = 1'b0;
		gen_ok  = 32'(cmd_gen) < N_GEN;
		per_new = '0;
		d             = q;
		d.val_pulse   = '0;
		d.rec_pulse   = 1'b0;
		cmd_ack       = 1'b0;
		cmd_refused   = 1'b0;

		// one cycle after release: take the period code and volatile defaults
		if (!q.booted) begin
			d.booted = 1'b1;
			if (period_code_nv <= wgs_pkg::PERIOD_CODE_MAX)
				per_new = CW'(SERVO_MIN_CYC + SERVO_STEP_CYC *
					32'(period_code_nv));
			else
				per_new = CW'(SERVO_MIN_CYC + SERVO_STEP_CYC *
					32'(wgs_pkg::PERIOD_CODE_DFLT));
			d.period = per_new;
			for (int g = 0; g < N_GEN; g++) begin
				d.rate[g]     = wgs_pkg::RATE_DFLT;
				d.trig_sel[g] = wgs_pkg::TRIG_SEL_DFLT;
				d.last[g]     = AW'(TBL_DEPTH - 1);
			end
		end else if (q.per_cnt == q.period - CW'(1)) begin
			d.per_cnt = '0;
			tick      = 1'b1;
		end else begin
			d.per_cnt = q.per_cnt + CW'(1);
		end

		// processing phase: one generator per clock, load high meanwhile
		if (tick) begin
			d.busy  = 1'b1;
			d.phase = '0;
		end else if (q.busy) begin
			if (32'(q.phase) == N_GEN - 1)
				d.busy = 1'b0;
			else
				d.phase = q.phase + PHW'(1);
		end

		for (int g = 0; g < N_GEN; g++) begin
			if (q.busy && 32'(q.phase) == g) begin
				if (q.stop_pend[g]) begin
					d.run[g]       = 1'b0;
					d.stop_pend[g] = 1'b0;
				end else if (q.run[g] && !(q.trig_mode[g] &&
					!trig_in[q.trig_sel[g]])) begin
					d.value[g] = q.offset[g] + q.base[g] +
						q.tbl[g][q.idx[g]];
					// analog control keeps the sequence but hides it
					d.val_pulse[g] = !analog_ctl[g];
					if (q.hold[g] + 16'h0001 >= q.rate[g]) begin
						d.hold[g] = '0;
						if (q.idx[g] == q.last[g]) begin
							d.idx[g]  = '0;
							d.done[g] = q.done[g] + 16'h0001;
							if (q.endpt[g])
								d.base[g] = q.base[g] + q.tbl[g][q.last[g]] -
									q.tbl[g][0];
							if (q.limit[g] != '0 &&
								q.done[g] + 16'h0001 >= q.limit[g])
								d.stop_pend[g] = 1'b1;
						end else begin
							d.idx[g] = q.idx[g] + AW'(1);
						end
					end else begin
						d.hold[g] = q.hold[g] + 16'h0001;
					end
				end
			end
		end

		// error code: a query clears it, a new stop in that cycle wins
		if (err_read)
			d.err = wgs_pkg::ERR_NONE;

		if (cmd_valid && q.booted) begin
			unique case (cmd_op)
				wgs_pkg::OP_WAVE_OUTPUT_CONTROL: begin
					if (!gen_ok) begin
						cmd_refused = 1'b1;
					end else if (cmd_arg == wgs_pkg::MODE_STOP) begin
						// stop is taken even under analog control
						d.stop_pend[cmd_gen] = q.run[cmd_gen];
						d.smode[cmd_gen]     = wgs_pkg::MODE_STOP;
						cmd_ack              = 1'b1;
					end else if (analog_ctl[cmd_gen] ||
						!(cmd_arg[wgs_pkg::MODE_IMM_BIT] ||
						cmd_arg[wgs_pkg::MODE_TRIG_BIT])) begin
						cmd_refused = 1'b1;
					end else begin
						d.smode[cmd_gen]     = cmd_arg;
						d.run[cmd_gen]       = 1'b1;
						d.stop_pend[cmd_gen] = 1'b0;
						d.idx[cmd_gen]       = '0;
						d.hold[cmd_gen]      = '0;
						d.done[cmd_gen]      = '0;
						d.base[cmd_gen]      = '0;
						d.trig_mode[cmd_gen] =
							!cmd_arg[wgs_pkg::MODE_IMM_BIT];
						d.endpt[cmd_gen] =
							cmd_arg[wgs_pkg::OPT_ENDPT_BIT];
						d.rec_pulse = cmd_arg[wgs_pkg::MODE_IMM_BIT];
						cmd_ack     = 1'b1;
					end
				end
				wgs_pkg::OP_GENERAL_STOP, wgs_pkg::OP_FAST_STOP: begin
					for (int g = 0; g < N_GEN; g++) begin
						d.stop_pend[g] = q.run[g];
						d.smode[g]     = wgs_pkg::MODE_STOP;
					end
					if (|q.run)
						d.err = wgs_pkg::ERR_WAVE_STOPPED;
					cmd_ack = 1'b1;
				end
				wgs_pkg::OP_RECORDING_RESTART: begin
					d.rec_pulse = |q.run;
					cmd_ack     = |q.run;
					cmd_refused = ~|q.run;
				end
				wgs_pkg::OP_CYCLE_LIMIT: begin
					// counting restarts at the moment the limit is written
					if (gen_ok) begin
						d.limit[cmd_gen] = cmd_arg;
						d.done[cmd_gen]  = '0;
					end
					cmd_ack     = gen_ok;
					cmd_refused = !gen_ok;
				end
				wgs_pkg::OP_POINT_HOLD_RATE: begin
					if (gen_ok && cmd_arg != '0) begin
						d.rate[cmd_gen] = cmd_arg;
						cmd_ack         = 1'b1;
					end else begin
						cmd_refused = 1'b1;
					end
				end
				wgs_pkg::OP_OUTPUT_OFFSET: begin
					if (gen_ok)
						d.offset[cmd_gen] = PT_W'(cmd_arg);
					cmd_ack     = gen_ok;
					cmd_refused = !gen_ok;
				end
				wgs_pkg::OP_TRIGGER_CONFIG: begin
					if (gen_ok)
						d.trig_sel[cmd_gen] = cmd_arg[1:0];
					cmd_ack     = gen_ok;
					cmd_refused = !gen_ok;
				end
				wgs_pkg::OP_TABLE_LENGTH: begin
					// length may not move under a running index
					if (gen_ok && !q.run[cmd_gen] && cmd_arg != '0 &&
						32'(cmd_arg) <= TBL_DEPTH) begin
						d.last[cmd_gen] = AW'(cmd_arg - 16'h0001);
						cmd_ack         = 1'b1;
					end else begin
						cmd_refused = 1'b1;
					end
				end
				wgs_pkg::OP_MOTION, wgs_pkg::OP_SERVO_MODE,
				wgs_pkg::OP_CONTROL_MODE: begin
					cmd_refused = !gen_ok || q.run[cmd_gen];
					cmd_ack     = gen_ok && !q.run[cmd_gen];
				end
				default: begin
					cmd_refused = 1'b1;
				end
			endcase
		end else if (cmd_valid) begin
			cmd_refused = 1'b1;
		end

		// table writes land in the generator's own store
		if (tbl_we && 32'(tbl_gen) < N_GEN)
			d.tbl[tbl_gen][tbl_addr] = tbl_data;
	end

	// state register; reset clears everything, defaults follow at boot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// outputs straight from the state register
	assign err_code        = q.err;
	assign running         = q.run;
	assign start_mode      = q.smode;
	assign gen_value       = q.value;
	assign gen_value_valid = q.val_pulse;
	assign rec_trigger     = q.rec_pulse;
	assign load_ind        = q.busy;
endmodule : wgs_top

// ===== wgs_top_sva.sv
// port level assertions for the wave generator sequencer
`timescale 1ns/10ps
module wgs_top_sva #(
	parameter int N_GEN = 2
) (
	input wire logic                 sys_clk,
	input wire logic                 rst_n,
	input wire logic                 cmd_valid,
	input wire wgs_pkg::wgs_op_t     cmd_op,
	input wire logic [0:0]           cmd_gen,
	input wire logic [15:0]          cmd_arg,
	input wire logic                 cmd_ack,
	input wire logic                 cmd_refused,
	input wire logic [N_GEN-1:0]     analog_ctl,
	input wire logic [7:0]           err_code,
	input wire logic [N_GEN-1:0]     running,
	input wire logic [N_GEN*16-1:0]  start_mode,
	input wire logic [N_GEN-1:0]     gen_value_valid,
	input wire logic                 rec_trigger,
	input wire logic                 load_ind
);
	// decoded strobes; tk means the command was taken
	wire logic tk = cmd_valid && cmd_ack;
	wire logic wo = cmd_valid && cmd_op == wgs_pkg::OP_WAVE_OUTPUT_CONTROL;
	wire logic general_stop_cmd = tk && (cmd_op == wgs_pkg::OP_GENERAL_STOP ||
		cmd_op == wgs_pkg::OP_FAST_STOP);
	wire logic run_g = running[cmd_gen];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// stop bound of 90 cycles assumes the shortened servo period
	a_imm_rec: assert property (tk && wo &&
		cmd_arg[0] |=> rec_trigger)
		else $error("immediate start gave no recording pulse");
	a_restart_rec: assert property (tk &&
		cmd_op == wgs_pkg::OP_RECORDING_RESTART |=> rec_trigger)
		else $error("recording restart gave no pulse");
	a_motion_block: assert property (cmd_valid &&
		cmd_op == wgs_pkg::OP_MOTION && run_g |-> cmd_refused)
		else $error("motion taken on running axis");
	a_mode_block: assert property (cmd_valid && run_g &&
		(cmd_op == wgs_pkg::OP_SERVO_MODE ||
		cmd_op == wgs_pkg::OP_CONTROL_MODE) |-> cmd_refused)
		else $error("mode change taken on running axis");
	a_analog_start: assert property (wo && cmd_arg != 16'h0 &&
		analog_ctl[cmd_gen] |-> cmd_refused)
		else $error("start taken under analog control");
	a_stop_err: assert property (general_stop_cmd && |running |=>
		err_code == 8'h0a)
		else $error("stop of running output left no error code");
	a_stop_mode: assert property (general_stop_cmd |=> start_mode == '0)
		else $error("stop left a start mode");
	a_emit_phase: assert property (|gen_value_valid |->
		$past(load_ind))
		else $error("value emitted outside servo processing");
	a_load_width: assert property ($rose(load_ind) |->
		load_ind ##1 load_ind ##1 !load_ind)
		else $error("load indicator width wrong");
	a_stop_clear: assert property (tk && wo && cmd_arg == 16'h0 &&
		cmd_gen == 1'h0 |-> ##[1:90] !running[0])
		else $error("stopped generator still running");

	// main scenarios reached
	c_stop: cover property (general_stop_cmd);
	c_endpt: cover property (tk && wo && cmd_arg[8]);
	c_fall: cover property ($fell(running[0]));
endmodule : wgs_top_sva

bind wgs_top wgs_top_sva #(.N_GEN(N_GEN)) sva_u (.sys_clk, .rst_n,
	.cmd_valid, .cmd_op, .cmd_gen, .cmd_arg, .cmd_ack, .cmd_refused,
	.analog_ctl, .err_code, .running, .start_mode, .gen_value_valid,
	.rec_trigger, .load_ind);

// ===== wgs_top_tb.sv
// self-checking bench for the wave generator sequencer
`timescale 1ns/10ps
module wgs_top_tb;
	logic sys_clk, rst_n, tbl_we, err_read, cmd_valid, cmd_ack;
	logic cmd_refused, rec_trigger, load_ind;
	logic [0:0] cmd_gen;
	logic [3:0] tbl_addr, trig_in;
	logic [1:0] analog_ctl, running, gen_value_valid;
	logic [7:0] err_code;
	logic [15:0] cmd_arg, tbl_data, off, pt[4], ansq[$], expq[$];
	logic [31:0] start_mode, gen_value, rs = 32'h8113c6d0;
	wgs_pkg::wgs_op_t cmd_op;
	int err_count, check_count;

	wgs_host host_u (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_gen(cmd_gen), .cmd_arg(cmd_arg));
	wgs_top #(.SERVO_MIN_CYC(20), .SERVO_STEP_CYC(5)) dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .period_code_nv(3'h4),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_gen(cmd_gen),
		.cmd_arg(cmd_arg), .cmd_ack(cmd_ack), .cmd_refused(cmd_refused),
		.tbl_we(tbl_we), .tbl_gen(1'h0), .tbl_addr(tbl_addr),
		.tbl_data(tbl_data), .trig_in(trig_in), .analog_ctl(analog_ctl),
		.err_read(err_read), .err_code(err_code), .running(running),
		.start_mode(start_mode), .gen_value(gen_value),
		.gen_value_valid(gen_value_valid), .rec_trigger(rec_trigger),
		.load_ind(load_ind));

	// 100 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// note the expected answer, then let the host send it
	task automatic cmd(input wgs_pkg::wgs_op_t op, input logic g,
		input logic [15:0] a, input logic ok);
		ansq.push_back({15'h0, ok});
		host_u.send(op, g, a);
	endtask : cmd

	// value stream of one run: hold rate r, endpoint option e
	task automatic note(input int n, input int r, input logic e);
		for (int k = 0; k < n; k++) begin
			expq.push_back(off + pt[(k / r) % 4] +
				(e ? 16'((k / (r * 4)) * (pt[3] - pt[0])) : 16'h0));
		end
	endtask : note

	// bounded wait for the stream to drain (q=0) or gen 0 to stop (q=1)
	task automatic wt(input logic q);
		for (int i = 0; i < 600; i++) begin
			if (q ? running[0] === 1'h0 : expq.size() == 0) return;
			@(negedge sys_clk);
		end
		err_count++;
		test_done();
	endtask : wt

	// cycles from one rise of the load indicator to the next, and its
	// high time; starting p high keeps a pulse in flight from counting
	task automatic per(input logic [15:0] exp);
		int n;
		int r;
		int h;
		logic p;
		n = 0;
		r = 0;
		h = 0;
		p = 1'h1;
		for (int i = 0; i < 300 && r < 2; i++) begin
			@(negedge sys_clk);
			if (r > 0)
				n++;
			if (load_ind && !p)
				r++;
			if (r == 1 && load_ind)
				h++;
			p = load_ind;
		end
		chk(16'(n), exp);
		chk(16'(h), 16'h2);
	endtask : per

	// between edges answers and values are settled; pop the oldest note
	always @(negedge sys_clk) begin
		if (cmd_ack || cmd_refused)
			chk({15'h0, cmd_ack}, ansq.size() ? ansq.pop_front() : 'x);
		if (gen_value_valid[0])
			chk(gen_value[15:0], expq.size() ? expq.pop_front() : 'x);
	end

	initial begin
		{rst_n, tbl_we, err_read, tbl_addr, tbl_data, analog_ctl} = '0;
		trig_in = 4'h0;
		repeat (16) @(negedge sys_clk);
		rst_n <= 1'h1;
		// random table of four points, written after reset release
		for (int i = 0; i < 4; i++) begin
			pt[i] = 16'(rnd());
			@(negedge sys_clk);
			tbl_we <= 1'h1;
			tbl_addr <= 4'(i);
			tbl_data <= pt[i];
		end
		@(negedge sys_clk);
		tbl_we <= 1'h0;
		off = 16'(rnd());
		// code 4 on the shortened scale 20 + n * 5 gives 40 cycles
		per(16'h28);
		cmd(wgs_pkg::OP_TABLE_LENGTH, 0, 16'h4, 1);
		cmd(wgs_pkg::OP_OUTPUT_OFFSET, 0, off, 1);
		cmd(wgs_pkg::OP_POINT_HOLD_RATE, 0, 16'h0, 0);
		note(6, 1, 0);
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h1, 1);
		cmd(wgs_pkg::OP_MOTION, 0, 16'h5, 0);
		cmd(wgs_pkg::OP_SERVO_MODE, 0, 16'h0, 0);
		cmd(wgs_pkg::OP_CONTROL_MODE, 0, 16'h1, 0);
		cmd(wgs_pkg::OP_RECORDING_RESTART, 0, 16'h0, 1);
		cmd(wgs_pkg::OP_MOTION, 1, 16'h5, 1);
		wt(0);
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h0, 1);
		wt(1);
		cmd(wgs_pkg::OP_POINT_HOLD_RATE, 0, 16'h2, 1);
		note(10, 2, 1);
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h0101, 1);
		chk(start_mode[15:0], 16'h0101);
		wt(0);
		cmd(wgs_pkg::OP_GENERAL_STOP, 0, 16'h0, 1);
		chk(err_code, 8'h0a);
		chk(start_mode[15:0], 16'h0);
		err_read <= 1'h1;
		@(negedge sys_clk);
		err_read <= 1'h0;
		chk(err_code, 8'h0);
		wt(1);
		analog_ctl <= 2'h1;
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h1, 0);
		analog_ctl <= 2'h0;
		cmd(wgs_pkg::OP_POINT_HOLD_RATE, 0, 16'h1, 1);
		cmd(wgs_pkg::OP_CYCLE_LIMIT, 0, 16'h2, 1);
		note(8, 1, 0);
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h1, 1);
		wt(0);
		wt(1);
		// trigger start: paused while the selected input is low
		note(4, 1, 0);
		cmd(wgs_pkg::OP_WAVE_OUTPUT_CONTROL, 0, 16'h2, 1);
		repeat (100) @(negedge sys_clk);
		chk(running, 2'h1);
		trig_in <= 4'h1;
		wt(0);
		// analog control hides the stream but keeps it running
		analog_ctl <= 2'h1;
		repeat (100) @(negedge sys_clk);
		chk(running, 2'h1);
		trig_in <= 4'h0;
		analog_ctl <= 2'h0;
		cmd(wgs_pkg::OP_FAST_STOP, 0, 16'h0, 1);
		chk(err_code, 8'h0a);
		chk(start_mode[15:0], 16'h0);
		// let the monitor take the last answer before the verdict
		@(negedge sys_clk);
		test_done();
	end
endmodule : wgs_top_tb
